// >>> svss_pkg.sv
package svss_pkg;
   // Register indices; the byte address is four times the index.
   localparam int unsigned IDX_OUT_TABLE   = 0;
   localparam int unsigned IDX_IN_TABLE    = 1;
   localparam int unsigned IDX_MON_TIME    = 2;
   localparam int unsigned IDX_RESERVED    = 3;
   localparam int unsigned IDX_STATUS      = 4;
   localparam int unsigned IDX_STOP_NODE   = 5;
   localparam int unsigned IDX_OUT_MISSING = 6;
   localparam int unsigned IDX_IN_MISSING  = 7;
   localparam int unsigned IDX_OUT_UNREG   = 8;
   localparam int unsigned IDX_IN_UNREG    = 9;
   localparam int unsigned IDX_CONTROL     = 10;
   localparam int unsigned ADDR_W          = 8;

   // Bit positions in the network status flags word.
   localparam int unsigned BIT_REG_DONE    = 0;
   localparam int unsigned BIT_MISSING     = 8;
   localparam int unsigned BIT_UNREG       = 9;
   localparam int unsigned BIT_STOPPED     = 10;
   localparam int unsigned BIT_ERROR       = 15;

   // Fields of the stopped node info word.
   localparam int unsigned NODE_LSB        = 0;
   localparam int unsigned NODE_W          = 8;
   localparam int unsigned BIT_STOP_TYPE   = 15;

   // Control word bits.
   localparam int unsigned BIT_STOP_MODE   = 0;
   localparam int unsigned BIT_RESTART     = 1;

   // Widths and reset values.
   localparam int unsigned SLAVES          = 16;
   localparam int unsigned WORD_W          = 16;
   localparam logic [15:0] TABLE_RST       = 16'h0000;
   localparam logic [15:0] MON_TIME_RST    = 16'h0000;
   localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

   // One monitoring time unit, and its length in cycles of pclk.
   localparam int unsigned MON_UNIT_US     = 1000;
   localparam int unsigned CLK_MHZ         = 40;
   localparam int unsigned MON_UNIT_CYC    = MON_UNIT_US * CLK_MHZ;
endpackage

// >>> svss_status.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps
// Operation
// - Registration done sets once every registered slave has joined within the monitoring time, unregistered joiners notwithstanding.
// - Registration done never sets while the registration tables hold no slave.
// - Registration done stays set until power cycling or a unit restart.
// - The missing-slave flag sets when a registered slave has not joined by the end of the monitoring time.
// - The missing-slave flag clears by itself once the slaves that caused it have joined.
// - The unregistered-slave flag sets whenever a slave not in the tables joins.
// - The unregistered-slave flag stays set after that slave leaves, until power cycling or a unit restart.
// - In stop-on-error mode a halt on a communications error sets the communications-stopped flag.
// - The communications-stopped flag latches until power cycling or a unit restart.
// - The summary error flag is the OR of flag bits 08 to 10 and clears when all three are clear.
// - On a stop the offending node number is stored in the low byte of the second status word.
// - The stored node number is held until power cycling or a unit restart.
// - On a stop the offending slave's direction is stored in bit 15, zero for output and one for input.
// - The stored direction bit is held until power cycling or a unit restart.
// - Communications stop when any per-slave error flag sets in stop-on-error mode.
// - Each missing-slave bitmap bit maps to its node number and clears when that slave joins.
module svss_status
   import svss_pkg::*;
#(
   parameter int unsigned MON_UNIT_CYCLES = MON_UNIT_CYC
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ADDR_W-1:0]  paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic [SLAVES-1:0]  out_active,
   input  wire logic [SLAVES-1:0]  in_active,
   input  wire logic [SLAVES-1:0]  out_comm_err,
   input  wire logic [SLAVES-1:0]  in_comm_err,
   output logic                    comm_stop
);

   // Lowest set bit of a slave vector as a node number.
   function automatic logic [NODE_W-1:0] svss_first_node(input logic [SLAVES-1:0] v);
      logic [NODE_W-1:0] n;
      n = '0;
      for (int i = SLAVES - 1; i >= 0; i--) begin
         if (v[i]) begin
            n = NODE_W'(i);
         end
      end
      return n;
   endfunction

   // Two-stage synchronisers for the link-side flags.
   logic [SLAVES-1:0] oa_s1_q, oa_q, ia_s1_q, ia_q, oe_s1_q, oe_q, ie_s1_q, ie_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oa_s1_q <= '0;
         oa_q    <= '0;
         ia_s1_q <= '0;
         ia_q    <= '0;
         oe_s1_q <= '0;
         oe_q    <= '0;
         ie_s1_q <= '0;
         ie_q    <= '0;
      end else begin
         oa_s1_q <= out_active;
         oa_q    <= oa_s1_q;
         ia_s1_q <= in_active;
         ia_q    <= ia_s1_q;
         oe_s1_q <= out_comm_err;
         oe_q    <= oe_s1_q;
         ie_s1_q <= in_comm_err;
         ie_q    <= ie_s1_q;
      end
   end

   // Software-visible configuration and latched state.
   logic [WORD_W-1:0] out_table_q, in_table_q, mon_time_q;
   logic              stop_mode_q;
   logic [SLAVES-1:0] out_miss_q, in_miss_q, out_unreg_q, in_unreg_q, out_seen_q, in_seen_q;
   logic              reg_done_q, stopped_q, stop_type_q, window_done_q;
   logic [NODE_W-1:0] stop_node_q;
   logic [31:0]       prescale_q;
   logic [WORD_W-1:0] elapsed_q;
   logic [31:0]       prdata_q;
   logic              pready_q, pslverr_q;

   // APB decode: the transfer completes in the first access cycle.
   wire               setup_phase = psel && !penable && !pready_q;
   wire               wr_commit   = psel && penable && pready_q && pwrite;
   wire [ADDR_W-3:0]  reg_index   = paddr[ADDR_W-1:2];
   wire               idx_ok      = (reg_index <= (ADDR_W-2)'(IDX_CONTROL)) &&
                                    (reg_index != (ADDR_W-2)'(IDX_RESERVED));
   wire               wr_out_tbl  = wr_commit && (reg_index == (ADDR_W-2)'(IDX_OUT_TABLE));
   wire               wr_in_tbl   = wr_commit && (reg_index == (ADDR_W-2)'(IDX_IN_TABLE));
   wire               wr_mon      = wr_commit && (reg_index == (ADDR_W-2)'(IDX_MON_TIME));
   wire               wr_ctl      = wr_commit && (reg_index == (ADDR_W-2)'(IDX_CONTROL));
   wire               restart     = wr_ctl && pwdata[BIT_RESTART];

   // Monitoring window; a restart reopens it.
   wire               tick        = (prescale_q == MON_UNIT_CYCLES - 1);
   wire               window_end  = !window_done_q && (elapsed_q >= mon_time_q);

   // Slave classification against the registration tables.
   wire [SLAVES-1:0]  out_unreg_now = oa_q & ~out_table_q;
   wire [SLAVES-1:0]  in_unreg_now  = ia_q & ~in_table_q;
   wire               tables_empty  = (out_table_q == TABLE_RST) && (in_table_q == TABLE_RST);
   // A slave counts as joined once seen inside the window, even if it has left since.
   wire [SLAVES-1:0]  out_joined    = out_seen_q | oa_q;
   wire [SLAVES-1:0]  in_joined     = in_seen_q | ia_q;
   wire               all_joined    = ((out_table_q & ~out_joined) == '0) && ((in_table_q & ~in_joined) == '0);
   wire               any_err       = (oe_q != '0) || (ie_q != '0);
   wire               stop_event    = stop_mode_q && any_err && !stopped_q;

   // Assembled read words.
   wire               miss_flag  = (out_miss_q != '0) || (in_miss_q != '0);
   wire               unreg_flag = (out_unreg_q != '0) || (in_unreg_q != '0);
   logic [WORD_W-1:0] status_word, node_word;
   always_comb begin
      status_word                = '0;
      status_word[BIT_REG_DONE]  = reg_done_q;
      status_word[BIT_MISSING]   = miss_flag;
      status_word[BIT_UNREG]     = unreg_flag;
      status_word[BIT_STOPPED]   = stopped_q;
      status_word[BIT_ERROR]     = miss_flag || unreg_flag || stopped_q;
      node_word                  = '0;
      node_word[NODE_LSB +: NODE_W] = stop_node_q;
      node_word[BIT_STOP_TYPE]   = stop_type_q;
   end

   // Read multiplexer; reserved upper bits read as zero.
   logic [WORD_W-1:0] rd_word;
   always_comb begin
      unique case (reg_index)
         (ADDR_W-2)'(IDX_OUT_TABLE):   rd_word = out_table_q;
         (ADDR_W-2)'(IDX_IN_TABLE):    rd_word = in_table_q;
         (ADDR_W-2)'(IDX_MON_TIME):    rd_word = mon_time_q;
         (ADDR_W-2)'(IDX_STATUS):      rd_word = status_word;
         (ADDR_W-2)'(IDX_STOP_NODE):   rd_word = node_word;
         (ADDR_W-2)'(IDX_OUT_MISSING): rd_word = out_miss_q;
         (ADDR_W-2)'(IDX_IN_MISSING):  rd_word = in_miss_q;
         (ADDR_W-2)'(IDX_OUT_UNREG):   rd_word = out_unreg_q;
         (ADDR_W-2)'(IDX_IN_UNREG):    rd_word = in_unreg_q;
         (ADDR_W-2)'(IDX_CONTROL):     rd_word = {{(WORD_W-1){1'b0}}, stop_mode_q};
         default:                      rd_word = '0;
      endcase
   end

   // Bus answer: ready rises in the first access cycle; unmapped words answer with an error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= RDATA_RST;
      end else begin
         pready_q  <= setup_phase;
         pslverr_q <= setup_phase && !idx_ok;
         prdata_q  <= (setup_phase && !pwrite && idx_ok) ? {{(32-WORD_W){1'b0}}, rd_word} : RDATA_RST;
      end
   end

   // Configuration words, held as loaded at start-up by the host.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_table_q <= TABLE_RST;
         in_table_q  <= TABLE_RST;
         mon_time_q  <= MON_TIME_RST;
         stop_mode_q <= 1'b0;
      end else begin
         if (wr_out_tbl) out_table_q <= pwdata[WORD_W-1:0];
         if (wr_in_tbl)  in_table_q  <= pwdata[WORD_W-1:0];
         if (wr_mon)     mon_time_q  <= pwdata[WORD_W-1:0];
         if (wr_ctl)     stop_mode_q <= pwdata[BIT_STOP_MODE];
      end
   end

   // Monitoring timer: runs from reset or restart until the window closes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_q    <= '0;
         elapsed_q     <= '0;
         window_done_q <= 1'b0;
      end else if (restart) begin
         prescale_q    <= '0;
         elapsed_q     <= '0;
         window_done_q <= 1'b0;
      end else if (!window_done_q) begin
         prescale_q    <= tick ? '0 : prescale_q + 32'd1;
         elapsed_q     <= tick ? elapsed_q + 16'd1 : elapsed_q;
         window_done_q <= window_end;
      end
   end

   // Join history inside the window, so that a slave that joined and then left is not reported missing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_seen_q <= '0;
         in_seen_q  <= '0;
      end else if (restart) begin
         out_seen_q <= '0;
         in_seen_q  <= '0;
      end else if (!window_done_q) begin
         out_seen_q <= out_seen_q | oa_q;
         in_seen_q  <= in_seen_q | ia_q;
      end
   end

   // Registration done and the verification bitmaps; a restart stands for a unit restart.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_done_q  <= 1'b0;
         out_miss_q  <= '0;
         in_miss_q   <= '0;
         out_unreg_q <= '0;
         in_unreg_q  <= '0;
      end else if (restart) begin
         reg_done_q  <= 1'b0;
         out_miss_q  <= '0;
         in_miss_q   <= '0;
         out_unreg_q <= '0;
         in_unreg_q  <= '0;
      end else begin
         // Only inside the window, and never with empty tables.
         if (!window_done_q && !tables_empty && all_joined) reg_done_q <= 1'b1;
         // Missing bits load at window end from registered slaves not joined in the window, then fall as each joins.
         if (window_end) begin
            out_miss_q <= out_table_q & ~out_joined;
            in_miss_q  <= in_table_q & ~in_joined;
         end else begin
            out_miss_q <= out_miss_q & ~oa_q;
            in_miss_q  <= in_miss_q & ~ia_q;
         end
         out_unreg_q <= out_unreg_q | out_unreg_now;
         in_unreg_q  <= in_unreg_q | in_unreg_now;
      end
   end

   // Stop latch: the first error seen wins; output slaves take priority over input slaves.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stopped_q   <= 1'b0;
         stop_node_q <= '0;
         stop_type_q <= 1'b0;
      end else if (restart) begin
         stopped_q   <= 1'b0;
         stop_node_q <= '0;
         stop_type_q <= 1'b0;
      end else if (stop_event) begin
         stopped_q   <= 1'b1;
         stop_node_q <= (oe_q != '0) ? svss_first_node(oe_q) : svss_first_node(ie_q);
         stop_type_q <= (oe_q == '0);
      end
   end

   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = pslverr_q;
   assign comm_stop = stopped_q;

   a_done_needs_slaves: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(reg_done_q) |-> $past(!tables_empty && all_joined))
      else $error("Registration done set without all registered slaves.");

   a_done_holds: assert property (@(posedge pclk) disable iff (!presetn)
      reg_done_q && !restart |=> reg_done_q)
      else $error("Registration done dropped without restart.");

   a_miss_sets: assert property (@(posedge pclk) disable iff (!presetn)
      window_end && !restart && ((out_table_q & ~out_joined) != '0) |=> status_word[BIT_MISSING])
      else $error("Missing slave flag not set at window end.");

   a_miss_only_absent: assert property (@(posedge pclk) disable iff (!presetn)
      window_end && ((out_table_q & ~out_joined) == '0) && ((in_table_q & ~in_joined) == '0) |=> !miss_flag)
      else $error("Missing slave flag set although every registered slave joined.");

   a_miss_clears: assert property (@(posedge pclk) disable iff (!presetn)
      !window_end && ((out_miss_q & ~oa_q) == '0) && ((in_miss_q & ~ia_q) == '0) |=> !miss_flag)
      else $error("Missing slave flag kept after slaves joined.");

   a_unreg_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      unreg_flag && !restart |=> unreg_flag)
      else $error("Unregistered slave flag cleared without restart.");

   a_unreg_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (out_unreg_now != '0) && !restart |=> out_unreg_q != '0)
      else $error("Unregistered slave not recorded.");

   a_stop_sets: assert property (@(posedge pclk) disable iff (!presetn)
      stop_event && !restart |=> stopped_q && comm_stop)
      else $error("Stop event did not set the stopped flag.");

   a_stop_info_held: assert property (@(posedge pclk) disable iff (!presetn)
      stopped_q && !restart |=> $stable(stop_node_q) && $stable(stop_type_q) && stopped_q)
      else $error("Stopped node information changed.");

   a_error_summary: assert property (@(posedge pclk) disable iff (!presetn)
      pready_q && !pwrite && (reg_index == (ADDR_W-2)'(IDX_STATUS)) |->
         prdata_q[BIT_ERROR] == (prdata_q[BIT_MISSING] || prdata_q[BIT_UNREG] || prdata_q[BIT_STOPPED]))
      else $error("Summary error flag mismatch.");

   a_no_stop_off: assert property (@(posedge pclk) disable iff (!presetn)
      !stop_mode_q && !stopped_q |=> !stopped_q)
      else $error("Stop without stop mode.");

endmodule // svss_status

// >>> svss_net_model.sv
`timescale 1ns/1ps
// Slave network model: each call moves one slave's level just after a rising edge.
module svss_net_model (
   input  wire logic        pclk,
   output logic [15:0]      out_active,
   output logic [15:0]      in_active,
   output logic [15:0]      out_comm_err,
   output logic [15:0]      in_comm_err
);
   // All slaves start absent and error free.
   initial begin
      out_active   = 16'h0000;
      in_active    = 16'h0000;
      out_comm_err = 16'h0000;
      in_comm_err  = 16'h0000;
   end

   // Kind 0 and 1 are output and input joins, kind 2 and 3 output and input errors.
   task automatic set(input int k, input int n, input logic v);
      @(posedge pclk);
      case (k)
         0: out_active[n] <= v;
         1: in_active[n] <= v;
         2: out_comm_err[n] <= v;
         default: in_comm_err[n] <= v;
      endcase
   endtask
endmodule // svss_net_model

// >>> slave_verify_stop_status_tb.sv
`timescale 1ns/1ps
module slave_verify_stop_status_tb;
   import svss_pkg::*;
   logic                pclk;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [ADDR_W-1:0]   paddr;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic [SLAVES-1:0]   out_active;
   logic [SLAVES-1:0]   in_active;
   logic [SLAVES-1:0]   out_comm_err;
   logic [SLAVES-1:0]   in_comm_err;
   logic                comm_stop;
   logic [31:0]         rdat;
   logic                rerr;
   int                  bad_count;
   int                  cmp_count;

   // A short monitoring unit keeps the window at 80 cycles for 20 units.
   svss_status #(.MON_UNIT_CYCLES(4)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .out_active(out_active), .in_active(in_active), .out_comm_err(out_comm_err),
      .in_comm_err(in_comm_err), .comm_stop(comm_stop)
   );

   svss_net_model net (
      .pclk(pclk), .out_active(out_active), .in_active(in_active),
      .out_comm_err(out_comm_err), .in_comm_err(in_comm_err)
   );

   // Free running 40 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // One APB transfer; the answer is taken at the rising edge where pready is sampled high.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n == 50) bad_count++;
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'b0);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
      chk({31'h0, rerr}, {31'h0, ee});
   endtask

   // Link changes need three edges to reach the flags; five gives margin.
   task automatic lnk(input int k, input int n, input logic v);
      net.set(k, n, v);
      repeat (5) @(posedge pclk);
   endtask

   // Watchdog well beyond the expected run of a few hundred cycles.
   initial begin
      #500000;
      bad_count++;
      end_of_test();
   end

   initial begin
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0000_0000;
      bad_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Empty tables: nothing is reported, a write to the read-only status word is ignored, the reserved word refuses.
      xfer(1'b1, 8'h10, 32'h0000_ffff);
      xfer(1'b1, 8'h28, 32'h0000_0002);
      repeat (40) @(posedge pclk);
      rd(8'h10, 32'h0000_0000);
      rd(8'h14, 32'h0000_0000);
      rd(8'h0c, 32'h0000_0000, 1'b1);
      $display("test reset_and_refusal done");
      // Registered outputs 1 and 2, input 0, window of 20 units; output 5 joins unregistered.
      xfer(1'b1, 8'h00, 32'h0000_0006);
      xfer(1'b1, 8'h04, 32'h0000_0001);
      xfer(1'b1, 8'h08, 32'h0000_0014);
      xfer(1'b1, 8'h28, 32'h0000_0002);
      lnk(0, 1, 1'b1);
      lnk(0, 5, 1'b1);
      rd(8'h10, 32'h0000_8200);
      rd(8'h20, 32'h0000_0020);
      lnk(0, 2, 1'b1);
      lnk(1, 0, 1'b1);
      rd(8'h10, 32'h0000_8201);
      lnk(0, 5, 1'b0);
      lnk(0, 1, 1'b0);
      repeat (100) @(posedge pclk);
      rd(8'h10, 32'h0000_8201);
      $display("test registration done");
      // Restart with output 1 absent: it is reported missing until it joins.
      xfer(1'b1, 8'h28, 32'h0000_0002);
      repeat (100) @(posedge pclk);
      rd(8'h10, 32'h0000_8100);
      rd(8'h18, 32'h0000_0002);
      lnk(0, 1, 1'b1);
      rd(8'h18, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      $display("test missing slave done");
      // Stop mode: an input error stops traffic; a later output error changes nothing.
      xfer(1'b1, 8'h28, 32'h0000_0001);
      lnk(3, 7, 1'b1);
      chk({31'h0, comm_stop}, 32'h0000_0001);
      rd(8'h10, 32'h0000_8400);
      rd(8'h14, 32'h0000_8007);
      lnk(3, 7, 1'b0);
      lnk(2, 1, 1'b1);
      lnk(2, 1, 1'b0);
      rd(8'h14, 32'h0000_8007);
      rd(8'h10, 32'h0000_8400);
      $display("test stop on input done");
      // Restart keeping stop mode; an output error is recorded with direction zero.
      xfer(1'b1, 8'h28, 32'h0000_0003);
      repeat (5) @(posedge pclk);
      rd(8'h10, 32'h0000_0001);
      rd(8'h14, 32'h0000_0000);
      lnk(2, 3, 1'b1);
      rd(8'h14, 32'h0000_0003);
      rd(8'h10, 32'h0000_8401);
      lnk(2, 3, 1'b0);
      $display("test stop on output done");
      // Stop mode off: errors do not stop communications.
      xfer(1'b1, 8'h28, 32'h0000_0002);
      rd(8'h28, 32'h0000_0000);
      lnk(3, 4, 1'b1);
      chk({31'h0, comm_stop}, 32'h0000_0000);
      rd(8'h14, 32'h0000_0000);
      rd(8'h10, 32'h0000_0001);
      lnk(3, 4, 1'b0);
      $display("test stop mode off done");
      end_of_test();
   end
endmodule // slave_verify_stop_status_tb
